// >>> common/cscw_pkg.sv
// constants for the card status-change irq and window enable block
// assumes byte-wide register port with 12-bit socket-relative address
package cscw_pkg;
  localparam logic [7:0] OFF_FLAGS     = 8'h04;
  localparam logic [7:0] OFF_IRQ_CFG   = 8'h05;
  localparam logic [7:0] OFF_WIN_EN    = 8'h06;
  localparam logic [3:0] SOCKET_PAGE   = 4'h8;
  localparam logic [3:0] LOCAL_PAGE    = 4'h0;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] WIN_EN_WMASK  = 8'hDF;
  localparam logic [3:0] SEL_NONE      = 4'h0;
  localparam logic [3:0] SEL_IRQ1      = 4'h1;
  localparam logic [3:0] SEL_SMI       = 4'h2;
  localparam int         SEL_LSB       = 4;
  localparam int         EN_CD         = 3;
  localparam int         EN_READY      = 2;
  localparam int         EN_BATWARN    = 1;
  localparam int         EN_BATDEAD    = 0;
  localparam int         IOWIN1_BIT    = 7;
  localparam int         IOWIN0_BIT    = 6;
  localparam int         MEMWIN_BITS   = 5;
endpackage : cscw_pkg

// >>> hdl/cscw_irq_win.sv
// status-change interrupt routing/masking and address window enables
// assumes card pins are asynchronous; mode bits come from sibling regs
//
// Behaviour
// (RULE1) select field 7:4 routes to none, irq1, smi or irq3..irq15.
// (RULE2) select 0 with diagnostic bit set routes to pci, pci-route ignored.
// (RULE3) select 0 with diagnostic bit clear routes to pci only on pci-route.
// (RULE4) bit 3 lets card-detect changes raise a status change.
// (RULE5) bit 2 lets a ready rising edge raise a status change.
// (RULE6) bit 1 lets a battery warning raise a status change.
// (RULE7) bit 0 lets battery dead or card status signal raise a change.
// (RULE8) both registers reset to zero, masking and disabling everything.
// (RULE9) host cycles to a disabled window are never claimed.
// (RULE10) bits 7 and 6 enable io windows one and zero.
// (RULE11) bits 4..0 enable memory windows four..zero.
// (RULE12) window enable bit 5 always reads zero.
// (RULE13) config at 05h/805h, window enable at 06h/806h.
// (RULE14) disabled flags read zero; clear by read or write-one by mode.
// (RULE15) pci-route set sends status changes to pci interrupts.
// (RULE16) destination asserted while any enabled flag is set.
`timescale 1ns/10ps
module cscw_irq_win
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [11:0] regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // mode bits from neighbouring registers
  input  wire logic        statusChangePciRoute,
  input  wire logic        diagStatusChange,
  input  wire logic        flagClearByWrite,
  input  wire logic        cardIsIo,
  // card pins, asynchronous
  input  wire logic        cardDetect1N,
  input  wire logic        cardDetect2N,
  input  wire logic        cardReady,
  input  wire logic        batteryWarn,
  input  wire logic        batteryDeadStatus,
  // window decode and claim
  input  wire logic [4:0]  memWinHit,
  input  wire logic [1:0]  ioWinHit,
  output logic      [4:0]  memWinEn,
  output logic      [1:0]  ioWinEn,
  output logic             claimCycle,
  // interrupt destinations
  output logic      [15:0] legacyIrq,
  output logic             smiReq,
  output logic             pciIrqReq
);

  function automatic logic hitsReg(input logic [11:0] a,
                                   input logic [7:0]  off);
    hitsReg = (a == {cscw_pkg::LOCAL_PAGE, off}) ||
              (a == {cscw_pkg::SOCKET_PAGE, off});
  endfunction : hitsReg

  function automatic logic [15:0] selVec(input logic [3:0] sel);
    selVec = 16'h0000;
    if (sel != cscw_pkg::SEL_NONE && sel != cscw_pkg::SEL_SMI)
      selVec[sel] = 1'b1;
  endfunction : selVec

  logic [7:0] irqCfg_q;
  logic [7:0] winEn_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [4:0] pinPrev_q;
  logic [3:0] sel;
  logic [3:0] srcEn;
  logic [3:0] srcSet;
  logic [3:0] flagClr;
  logic [3:0] flagKeep;
  logic       anyFlag;
  logic       wrCfg;
  logic       wrWin;
  logic       wrFlags;
  logic       rdFlags;

  assign wrCfg   = regWr && hitsReg(regAddr, cscw_pkg::OFF_IRQ_CFG); // [RULE13]
  assign wrWin   = regWr && hitsReg(regAddr, cscw_pkg::OFF_WIN_EN);  // [RULE13]
  assign wrFlags = regWr && hitsReg(regAddr, cscw_pkg::OFF_FLAGS);
  assign rdFlags = regRd && hitsReg(regAddr, cscw_pkg::OFF_FLAGS);
  assign sel     = irqCfg_q[cscw_pkg::SEL_LSB +: 4];
  assign srcEn   = irqCfg_q[3:0];
  // io cards hold ready and warning flags at zero, even if set before
  assign flagKeep = cardIsIo ? 4'h9 : 4'hF; // [RULE5] [RULE6]

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqCfg_q <= cscw_pkg::REG_RESET; // [RULE8]
      winEn_q  <= cscw_pkg::REG_RESET; // [RULE8]
    end
    else
    begin
      if (wrCfg)
        irqCfg_q <= regWrData;
      if (wrWin)
        winEn_q <= regWrData & cscw_pkg::WIN_EN_WMASK; // [RULE12]
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinMeta_q <= 5'h00;
      pinSync_q <= 5'h00;
      pinPrev_q <= 5'h00;
    end
    else
    begin
      pinMeta_q <= {batteryDeadStatus, batteryWarn, cardReady,
                    cardDetect2N, cardDetect1N};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  // event sources; ready and battery warning only mean something on memory
  always_comb
  begin
    srcSet = 4'h0;
    srcSet[cscw_pkg::EN_CD]      = srcEn[cscw_pkg::EN_CD] &&
      (pinSync_q[1:0] != pinPrev_q[1:0]);                     // [RULE4]
    srcSet[cscw_pkg::EN_READY]   = srcEn[cscw_pkg::EN_READY] && !cardIsIo &&
      pinSync_q[2] && !pinPrev_q[2];                          // [RULE5]
    srcSet[cscw_pkg::EN_BATWARN] = srcEn[cscw_pkg::EN_BATWARN] && !cardIsIo &&
      pinSync_q[3];                                           // [RULE6]
    srcSet[cscw_pkg::EN_BATDEAD] = srcEn[cscw_pkg::EN_BATDEAD] &&
      pinSync_q[4];                                           // [RULE7]
  end

  // clear by read or by write-one; a set in the same cycle wins
  always_comb
  begin
    flagClr = 4'h0;
    if (flagClearByWrite && wrFlags)
      flagClr = regWrData[3:0]; // [RULE14]
    else if (!flagClearByWrite && rdFlags)
      flagClr = 4'hF;           // [RULE14]
    flags_d = ((flags_q & ~flagClr) | srcSet) & srcEn & flagKeep; // [RULE14]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_q <= 4'h0;
    else
      flags_q <= flags_d;
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRdData <= 8'h00;
    else if (regRd)
    begin
      if (hitsReg(regAddr, cscw_pkg::OFF_IRQ_CFG))
        regRdData <= irqCfg_q;
      else if (hitsReg(regAddr, cscw_pkg::OFF_WIN_EN))
        regRdData <= winEn_q & cscw_pkg::WIN_EN_WMASK; // [RULE12]
      else if (hitsReg(regAddr, cscw_pkg::OFF_FLAGS))
        regRdData <= {4'h0, flags_q & srcEn};          // [RULE14]
      else
        regRdData <= 8'h00;
    end
  end

  // window enables and cycle claim
  assign memWinEn = winEn_q[cscw_pkg::MEMWIN_BITS-1:0];    // [RULE11]
  assign ioWinEn  = {winEn_q[cscw_pkg::IOWIN1_BIT],
                     winEn_q[cscw_pkg::IOWIN0_BIT]};        // [RULE10]
  assign claimCycle = |(memWinHit & memWinEn) |
                      |(ioWinHit & ioWinEn);               // [RULE9]

  // interrupt destinations, level while any enabled flag is held
  assign anyFlag = |(flags_q & srcEn);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      legacyIrq <= 16'h0000;
      smiReq    <= 1'b0;
      pciIrqReq <= 1'b0;
    end
    else
    begin
      // pci route overrides legacy choice; diag bit forces pci when sel=0
      pciIrqReq <= anyFlag && (statusChangePciRoute ||
                   (sel == cscw_pkg::SEL_NONE && diagStatusChange)); // [RULE2] [RULE3] [RULE15] [RULE16]
      smiReq    <= anyFlag && !statusChangePciRoute &&
                   sel == cscw_pkg::SEL_SMI;                         // [RULE1] [RULE16]
      legacyIrq <= (anyFlag && !statusChangePciRoute) ?
                   selVec(sel) : 16'h0000;                           // [RULE1] [RULE15]
    end
  end

  cfg_reset_a: assert property (@(posedge clk)
    $past(sys_rst) |-> irqCfg_q == 8'h00 && winEn_q == 8'h00) // [RULE8]
    else $error("registers not cleared by reset");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(regRd) && hitsReg($past(regAddr), cscw_pkg::OFF_WIN_EN)
    |-> !regRdData[5]) // [RULE12]
    else $error("reserved window bit read as one");
  claim_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    claimCycle |-> |(memWinHit & winEn_q[4:0]) ||
    |(ioWinHit & winEn_q[7:6])) // [RULE9]
    else $error("cycle claimed for disabled window");
  flag_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !irqCfg_q[cscw_pkg::EN_CD] |=> !flags_q[cscw_pkg::EN_CD]) // [RULE4]
    else $error("masked card detect flag set");
  ready_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
    srcEn[cscw_pkg::EN_READY] && !cardIsIo && pinSync_q[2] &&
    !pinPrev_q[2] |=> flags_q[cscw_pkg::EN_READY]) // [RULE5]
    else $error("ready rise lost");
  batt_warn_a: assert property (@(posedge clk) disable iff (sys_rst)
    srcEn[1] && !cardIsIo && pinSync_q[3] |=> flags_q[1]) // [RULE6]
    else $error("battery warning lost");
  batt_dead_a: assert property (@(posedge clk) disable iff (sys_rst)
    srcEn[0] && pinSync_q[4] |=> flags_q[0]) // [RULE7]
    else $error("battery dead lost");
  smi_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyFlag && !statusChangePciRoute && sel == 4'h2 |=> smiReq) // [RULE1]
    else $error("smi not raised");
  pci_diag_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyFlag && sel == 4'h0 && diagStatusChange |=> pciIrqReq) // [RULE2]
    else $error("diag pci route missing");
  pci_plain_a: assert property (@(posedge clk) disable iff (sys_rst)
    sel == 4'h0 && !diagStatusChange && !statusChangePciRoute
    |=> !pciIrqReq && legacyIrq == 16'h0000) // [RULE3]
    else $error("route with select zero");
  pci_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyFlag && statusChangePciRoute |=> pciIrqReq && !smiReq) // [RULE15]
    else $error("pci route ignored");
  irq_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    !anyFlag |=> legacyIrq == 16'h0000 && !smiReq && !pciIrqReq) // [RULE16]
    else $error("interrupt held with no flag");
  set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
    (srcSet[0] && rdFlags) |=> flags_q[0]) // [RULE14]
    else $error("set lost to clear");
  cfg_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == 12'h805 |=> irqCfg_q == $past(regWrData)) // [RULE13]
    else $error("config not written at 805h");
  win_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrWin |=> ioWinEn[1] == $past(regWrData[7])
    && memWinEn == $past(regWrData[4:0])) // [RULE10] [RULE11]
    else $error("window enable map wrong");
  // more guards on masking, clearing and read-back
  io_win_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrWin |=> ioWinEn[0] == $past(regWrData[6])) // [RULE10]
    else $error("io window zero enable wrong");
  rd_cfg_a: assert property (@(posedge clk) disable iff (sys_rst)
    regRd && hitsReg(regAddr, cscw_pkg::OFF_IRQ_CFG)
    |=> regRdData == $past(irqCfg_q)) // [RULE13]
    else $error("config read back wrong");
  io_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    cardIsIo |=> !flags_q[cscw_pkg::EN_READY] &&
    !flags_q[cscw_pkg::EN_BATWARN]) // [RULE5] [RULE6]
    else $error("io card ready or warning flag set");
  cd_change_a: assert property (@(posedge clk) disable iff (sys_rst)
    srcEn[cscw_pkg::EN_CD] && pinSync_q[1:0] != pinPrev_q[1:0]
    |=> flags_q[cscw_pkg::EN_CD]) // [RULE4]
    else $error("card detect change lost");
  ready_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !srcEn[cscw_pkg::EN_READY] |=> !flags_q[cscw_pkg::EN_READY]) // [RULE5]
    else $error("masked ready flag set");
  warn_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !srcEn[cscw_pkg::EN_BATWARN]
    |=> !flags_q[cscw_pkg::EN_BATWARN]) // [RULE6]
    else $error("masked battery warning flag set");
  dead_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !srcEn[cscw_pkg::EN_BATDEAD]
    |=> !flags_q[cscw_pkg::EN_BATDEAD]) // [RULE7]
    else $error("masked battery dead flag set");
  wr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    flagClearByWrite && wrFlags && regWrData[3] && !srcSet[3]
    |=> !flags_q[3]) // [RULE14]
    else $error("write-one clear missed");
  rd_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    !flagClearByWrite && rdFlags && srcSet == 4'h0
    |=> flags_q == 4'h0) // [RULE14]
    else $error("read clear missed");
  irq_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    anyFlag && !statusChangePciRoute
    |=> legacyIrq == selVec($past(sel))) // [RULE1] [RULE16]
    else $error("legacy line does not follow select");
  flag_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
    regRd && hitsReg(regAddr, cscw_pkg::OFF_FLAGS)
    |=> regRdData[7:4] == 4'h0) // [RULE14]
    else $error("flag read upper bits set");
  one_dest_a: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot0({pciIrqReq, smiReq, |legacyIrq})) // [RULE1]
    else $error("more than one destination raised");

endmodule : cscw_irq_win

// >>> sim/cscw_card_model.sv
// card-side pin model for the status-change block
// assumes bench sets card conditions as plain levels
`timescale 1ns/10ps
module cscw_card_model
(
  // conditions from bench
  present,
  readyHi,
  warn,
  dead,
  // card pins
  cardDetect1N,
  cardDetect2N,
  cardReady,
  batteryWarn,
  batteryDeadStatus
);
  input  wire logic present;
  input  wire logic readyHi;
  input  wire logic warn;
  input  wire logic dead;
  output logic      cardDetect1N;
  output logic      cardDetect2N;
  output logic      cardReady;
  output logic      batteryWarn;
  output logic      batteryDeadStatus;
  // both detect pins low while seated, so one toggle moves both
  assign cardDetect1N      = ~present;
  assign cardDetect2N      = ~present;
  assign cardReady         = readyHi;
  assign batteryWarn       = warn;
  assign batteryDeadStatus = dead;
endmodule : cscw_card_model

// >>> sim/tb_card_status_irq_and_window_enable.sv
// self-checking bench for the status-change irq and window enable block
// assumes the card model above on the pin side
`timescale 1ns/10ps
module tb_card_status_irq_and_window_enable;
  logic        clk, sys_rst, regWr, regRd, pciRoute, diag, clrByWr, present;
  logic        readyHi, warn, dead, cd1N, cd2N, rdy, bw, bd, claimCycle;
  logic        smiReq, pciIrqReq, isIo;
  logic [11:0] regAddr;
  logic [7:0]  regWrData, regRdData, d;
  logic [4:0]  memWinHit, memWinEn;
  logic [1:0]  ioWinHit, ioWinEn;
  logic [15:0] legacyIrq;
  logic [3:0]  s;
  int          fails, n_compared;

  cscw_card_model cscw_card_model_inst (.present(present), .readyHi(readyHi),
    .warn(warn), .dead(dead), .cardDetect1N(cd1N), .cardDetect2N(cd2N),
    .cardReady(rdy), .batteryWarn(bw), .batteryDeadStatus(bd));
  cscw_irq_win cscw_irq_win_inst (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData(regRdData), .statusChangePciRoute(pciRoute),
    .diagStatusChange(diag), .flagClearByWrite(clrByWr), .cardIsIo(isIo),
    .cardDetect1N(cd1N), .cardDetect2N(cd2N), .cardReady(rdy),
    .batteryWarn(bw), .batteryDeadStatus(bd), .memWinHit(memWinHit),
    .ioWinHit(ioWinHit), .memWinEn(memWinEn), .ioWinEn(ioWinEn),
    .claimCycle(claimCycle), .legacyIrq(legacyIrq), .smiReq(smiReq),
    .pciIrqReq(pciIrqReq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [17:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask : rd

  // expected {pci, smi, legacy} for a select value and mode bits
  function automatic logic [17:0] route(input logic [3:0] sel,
                                        input logic pr, dg);
    if (pr || (sel == 4'h0 && dg))
      return 18'h20000;
    if (sel == 4'h0)
      return 18'h00000;
    if (sel == 4'h2)
      return 18'h10000;
    return {2'b00, 16'h0001 << sel};
  endfunction : route

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial
  begin
    #100us;
    fails++;
    wrap_up();
  end

  initial
  begin
    {regWr, regRd, pciRoute, diag, clrByWr, readyHi, warn, dead} = 8'h00;
    {regAddr, regWrData, memWinHit, ioWinHit} = 27'h0;
    present = 1'b1;
    isIo = 1'b0;
    sys_rst = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd({i[1] ? 4'h8 : 4'h0, 6'h01, i[0] ? 2'b10 : 2'b01}, d);
      chk("reset value", d, 18'h0);
    end
    $display("test reset done");
    wr(12'h806, 8'hA5);
    rd(12'h006, d);
    chk("window enable", d, 18'h85);
    chk("window outputs", {ioWinEn, memWinEn}, 18'h45);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      {ioWinHit, memWinHit} <= 7'h01 << i;
      #1;
      chk("claim", claimCycle, (18'h45 >> i) & 18'h1);
    end
    $display("test windows done");
    @(posedge clk);
    warn <= 1'b1;
    for (int k = 0; k < 19; k++)
    begin
      s = (k < 16) ? k[3:0] : ((k == 18) ? 4'h9 : 4'h0);
      @(posedge clk);
      pciRoute <= (k > 16);
      diag     <= (k == 16);
      wr(12'h805, {s, 4'h2});
      tick(3);
      chk("routing", {pciIrqReq, smiReq, legacyIrq},
          route(s, k > 16, k == 16));
    end
    wr(12'h805, 8'h30);
    tick(3);
    rd(12'h804, d);
    chk("masked flags", d, 18'h0);
    chk("masked irq", legacyIrq, 18'h0);
    @(posedge clk);
    {pciRoute, diag, warn} <= 3'b000;
    $display("test routing done");
    for (int b = 3; b >= 0; b--)
    begin
      @(posedge clk);
      clrByWr <= b[0];
      wr(12'h805, 8'h30 | (8'h01 << b));
      @(posedge clk);
      case (b)
        3: present <= 1'b0;
        2: readyHi <= 1'b1;
        1: warn <= 1'b1;
        default: dead <= 1'b1;
      endcase
      tick(5);
      chk("irq3 on", legacyIrq, 18'h8);
      rd(12'h804, d);
      chk("flag set", d, 18'h1 << b);
      @(posedge clk);
      {readyHi, warn, dead} <= 3'b000;
      tick(4);
      if (b[0])
        wr(12'h804, 8'h01 << b);
      else
        rd(12'h004, d);
      tick(3);
      rd(12'h804, d);
      chk("flag cleared", d, 18'h0);
      chk("irq3 off", legacyIrq, 18'h0);
    end
    $display("test sources done");
    @(posedge clk);
    isIo    <= 1'b1;
    clrByWr <= 1'b0;
    wr(12'h805, 8'h37);
    @(posedge clk);
    {readyHi, warn, dead} <= 3'b111;
    tick(5);
    chk("io card irq", legacyIrq, 18'h8);
    rd(12'h804, d);
    chk("io card flags", d, 18'h1);
    @(posedge clk);
    {readyHi, warn, dead} <= 3'b000;
    $display("test io card done");
    wrap_up();
  end
endmodule : tb_card_status_irq_and_window_enable
